// ==== include/ids_pkg.sv ====
package ids_pkg;

	// ********************************
	// register offsets (byte addresses)
	// ********************************
	localparam logic [7:0] OFS_SPLIT_CTRL = 8'h10;
	localparam logic [7:0] OFS_SPLIT_SCOPE = 8'h14;
	localparam logic [7:0] OFS_BANK0 = 8'h20;
	localparam logic [7:0] OFS_BANK1 = 8'h24;
	localparam logic [7:0] OFS_BANK2 = 8'h28;
	localparam logic [7:0] OFS_BANK3 = 8'h2C;
	localparam logic [7:0] OFS_SEG_SIZE = 8'h30;
	localparam logic [7:0] OFS_DATA_BASE = 8'h34;
	localparam logic [7:0] OFS_STACK_BASE = 8'h38;
	localparam logic [7:0] OFS_XPC = 8'h3C;
	localparam logic [7:0] OFS_PC = 8'h40;
	localparam logic [7:0] OFS_LAST_PHYS = 8'h44;

	// ********************************
	// field positions and masks
	// ********************************
	localparam int SPLIT_R_A16 = 0;
	localparam int SPLIT_R_A19 = 1;
	localparam int SPLIT_D_A16 = 2;
	localparam int SPLIT_D_A19 = 3;
	localparam int SPLIT_FORCE_CS2 = 4;
	localparam logic [7:0] SPLIT_MASK = 8'h1F;
	localparam int BANK_SEL_CS2 = 0;
	localparam int BANK_INV_A18 = 4;
	localparam int BANK_INV_A19 = 5;
	localparam logic [3:0] XPC_WINDOW_PAGE = 4'hE;

	// ********************************
	// reset values
	// ********************************
	localparam logic [7:0] RST_SPLIT = 8'h00;
	localparam logic RST_SCOPE = 1'b1;
	localparam logic [7:0] RST_BANK = 8'h00;
	localparam logic [7:0] RST_SEG_SIZE = 8'h00;
	localparam logic [7:0] RST_BASE = 8'h00;
	localparam logic [7:0] RST_XPC = 8'h00;
	localparam logic [15:0] RST_PC = 16'h0000;

	// ********************************
	// types
	// ********************************
	typedef enum logic [1:0] {
		ZONE_ROOT = 2'b00,
		ZONE_DATA = 2'b01,
		ZONE_STACK = 2'b10,
		ZONE_XPC = 2'b11
	} ids_zone_t;

	typedef struct packed {
		logic valid;
		logic isData;
		logic [15:0] logAddr;
	} ids_req_t;

	typedef struct packed {
		logic [19:0] physAddr;
		logic [1:0] quadrant;
		logic csPrimary;
		logic csSecondary;
		ids_zone_t zone;
	} ids_map_t;

	typedef struct packed {
		logic valid;
		logic isLong;
		logic [15:0] target;
		logic [7:0] page;
	} ids_xfer_t;

	typedef struct packed {
		logic [7:0] split;
		logic scope;
		logic [3:0][7:0] bank;
		logic [7:0] segment_boundary_size;
		logic [7:0] dataBase;
		logic [7:0] stackBase;
		logic [7:0] extended_code_page;
	} ids_cfg_t;

endpackage

// ==== rtl/ids_xlate.sv ====
`timescale 1ns/1ps
module ids_xlate (
	input ids_pkg::ids_req_t req,
	input ids_pkg::ids_cfg_t cfg,
	output ids_pkg::ids_map_t map
);
	import ids_pkg::*;

	logic [3:0] page;
	logic [7:0] base;
	logic [19:0] addr;
	logic [7:0] sel;
	logic invOn;
	ids_zone_t zone;

	// ********************************
	// zone, inversion, bank choice
	// ********************************
	always_comb begin
		page = req.logAddr[15:12];
		if (page >= XPC_WINDOW_PAGE) begin
			zone = ZONE_XPC;
			base = cfg.extended_code_page;
		end else if (page >= cfg.segment_boundary_size[7:4]) begin
			zone = ZONE_STACK;
			base = cfg.stackBase;
		end else if (page >= cfg.segment_boundary_size[3:0]) begin
			zone = ZONE_DATA;
			base = cfg.dataBase;
		end else begin
			zone = ZONE_ROOT;
			base = 8'h00;
		end
		addr = {4'h0, req.logAddr} + {base, 12'h000};
		invOn = !cfg.scope || req.isData;
		if (invOn && zone == ZONE_ROOT) begin
			addr[19] = addr[19] ^ cfg.split[SPLIT_R_A19];
			addr[16] = addr[16] ^ cfg.split[SPLIT_R_A16];
		end else if (invOn && zone == ZONE_DATA) begin
			addr[19] = addr[19] ^ cfg.split[SPLIT_D_A19];
			addr[16] = addr[16] ^ cfg.split[SPLIT_D_A16];
		end
		map.quadrant = addr[19:18];
		sel = cfg.bank[addr[19:18]];
		addr[18] = addr[18] ^ sel[BANK_INV_A18];
		addr[19] = addr[19] ^ sel[BANK_INV_A19];
		map.physAddr = addr;
		map.csSecondary = sel[BANK_SEL_CS2] | cfg.split[SPLIT_FORCE_CS2];
		map.csPrimary = !sel[BANK_SEL_CS2];
		map.zone = zone;
	end

endmodule

// ==== rtl/ids_pc_unit.sv ====
`timescale 1ns/1ps
module ids_pc_unit (
	input logic clk,
	input logic rst_n,
	input ids_pkg::ids_xfer_t xfer,
	input logic busWr,
	input logic [7:0] busXpc,
	output logic [15:0] programCounter,
	output logic [7:0] extendedCodePage
);
	import ids_pkg::*;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0] extended_code_page;
	} ids_pc_state_t;

	ids_pc_state_t q;
	ids_pc_state_t n;

	// ********************************
	// transfer of control
	// ********************************
	always_comb begin
		n = q;
		if (xfer.valid) begin
			n.pc = xfer.target;
			if (xfer.isLong) begin
				n.extended_code_page = xfer.page;
			end
		end
		if (busWr) begin
			n.extended_code_page = busXpc;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{pc: RST_PC, extended_code_page: RST_XPC};
		end else begin
			q <= n;
		end
	end

	assign programCounter = q.pc;
	assign extendedCodePage = q.extended_code_page;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	long_xfer_a: assert property (
		xfer.valid && xfer.isLong && !busWr |=>
			q.pc == $past(xfer.target) && q.extended_code_page == $past(xfer.page))
		else $error("long transfer did not load counter and page");

	short_keep_a: assert property (
		xfer.valid && !xfer.isLong && !busWr |=> $stable(q.extended_code_page) && q.pc == $past(xfer.target))
		else $error("short transfer changed page register");

endmodule

// ==== rtl/ids_split_top.sv ====
`timescale 1ns/1ps
module ids_split_top (
	input logic clk,
	input logic rst_n,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input ids_pkg::ids_req_t memReq,
	input ids_pkg::ids_xfer_t xfer,
	output logic memValid,
	output ids_pkg::ids_map_t memMap,
	output logic [15:0] programCounter,
	output logic [7:0] extendedCodePage
);
	import ids_pkg::*;

	typedef struct packed {
		logic dataPhase;
		logic dpWrite;
		logic dpHit;
		logic [7:0] dpAddr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic [7:0] split;
		logic scope;
		logic [3:0][7:0] bank;
		logic [7:0] segment_boundary_size;
		logic [7:0] dataBase;
		logic [7:0] stackBase;
		logic memValid;
		ids_map_t memMap;
	} ids_top_state_t;

	ids_top_state_t q;
	ids_top_state_t n;
	ids_cfg_t cfg;
	ids_cfg_t refCfg;
	ids_map_t xlMap;
	ids_map_t refMap;
	logic busWrXpc;
	logic [7:0] xpcView;

	// ********************************
	// translation path
	// ********************************
	always_comb begin
		cfg.split = q.split;
		cfg.scope = q.scope;
		cfg.bank = q.bank;
		cfg.segment_boundary_size = q.segment_boundary_size;
		cfg.dataBase = q.dataBase;
		cfg.stackBase = q.stackBase;
		cfg.extended_code_page = extendedCodePage;
		refCfg = cfg;
		refCfg.split = q.split & 8'h10;
	end

	ids_xlate xlMain (
		.req(memReq),
		.cfg(cfg),
		.map(xlMap)
	);

	// reference path with no split inversion, read only by checks
	ids_xlate xlRef (
		.req(memReq),
		.cfg(refCfg),
		.map(refMap)
	);

	assign busWrXpc = q.dataPhase && q.dpWrite && q.dpHit && q.dpAddr == OFS_XPC;
	assign xpcView = busWrXpc ? hwdata[7:0] : extendedCodePage;

	ids_pc_unit pcUnit (
		.clk(clk),
		.rst_n(rst_n),
		.xfer(xfer),
		.busWr(busWrXpc),
		.busXpc(hwdata[7:0]),
		.programCounter(programCounter),
		.extendedCodePage(extendedCodePage)
	);

	// ********************************
	// register read mux
	// ********************************
	function automatic logic [31:0] regRead(input ids_top_state_t s, input logic [7:0] xpcNow,
		input logic [15:0] pcNow, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OFS_SPLIT_CTRL: r = {24'h00_0000, s.split};
			OFS_SPLIT_SCOPE: r = {31'h0000_0000, s.scope};
			OFS_BANK0: r = {24'h00_0000, s.bank[0]};
			OFS_BANK1: r = {24'h00_0000, s.bank[1]};
			OFS_BANK2: r = {24'h00_0000, s.bank[2]};
			OFS_BANK3: r = {24'h00_0000, s.bank[3]};
			OFS_SEG_SIZE: r = {24'h00_0000, s.segment_boundary_size};
			OFS_DATA_BASE: r = {24'h00_0000, s.dataBase};
			OFS_STACK_BASE: r = {24'h00_0000, s.stackBase};
			OFS_XPC: r = {24'h00_0000, xpcNow};
			OFS_PC: r = {16'h0000, pcNow};
			OFS_LAST_PHYS: r = {12'h000, s.memMap.physAddr};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ********************************
	// bus slave and registers
	// ********************************
	always_comb begin
		n = q;
		if (q.dataPhase && q.dpWrite && q.dpHit) begin
			case (q.dpAddr)
				OFS_SPLIT_CTRL: n.split = hwdata[7:0] & SPLIT_MASK;
				OFS_SPLIT_SCOPE: n.scope = hwdata[0];
				OFS_BANK0: n.bank[0] = hwdata[7:0];
				OFS_BANK1: n.bank[1] = hwdata[7:0];
				OFS_BANK2: n.bank[2] = hwdata[7:0];
				OFS_BANK3: n.bank[3] = hwdata[7:0];
				OFS_SEG_SIZE: n.segment_boundary_size = hwdata[7:0];
				OFS_DATA_BASE: n.dataBase = hwdata[7:0];
				OFS_STACK_BASE: n.stackBase = hwdata[7:0];
				default: n.dataPhase = q.dataPhase;
			endcase
		end
		n.dataPhase = 1'b0;
		n.hreadyout = 1'b1;
		if (hready && hsel && htrans[1]) begin
			n.dataPhase = 1'b1;
			n.dpWrite = hwrite;
			n.dpHit = haddr[31:8] == 24'h00_0000;
			n.dpAddr = haddr[7:0];
			if (!hwrite) begin
				n.hrdata = (haddr[31:8] == 24'h00_0000) ?
					regRead(n, xpcView, programCounter, haddr[7:0]) : 32'h0000_0000;
			end
		end
		n.memValid = memReq.valid;
		if (memReq.valid) begin
			n.memMap = xlMap;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{dataPhase: 1'b0, dpWrite: 1'b0, dpHit: 1'b0, dpAddr: 8'h00,
				hreadyout: 1'b1, hrdata: 32'h0000_0000, split: RST_SPLIT, scope: RST_SCOPE,
				bank: {4{RST_BANK}}, segment_boundary_size: RST_SEG_SIZE, dataBase: RST_BASE,
				stackBase: RST_BASE, memValid: 1'b0, memMap: '0};
		end else begin
			q <= n;
		end
	end

	assign hreadyout = q.hreadyout;
	assign hrdata = q.hrdata;
	assign hresp = 1'b0;
	assign memValid = q.memValid;
	assign memMap = q.memMap;

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	fetch_no_invert_a: assert property (
		memReq.valid && !memReq.isData && q.scope |=> q.memMap == $past(refMap))
		else $error("instruction fetch was inverted");

	scope_clear_a: assert property (
		memReq.valid && !q.scope && memReq.logAddr[15:12] < q.segment_boundary_size[3:0] &&
			memReq.logAddr[15:12] < q.segment_boundary_size[7:4] &&
			memReq.logAddr[15:12] < XPC_WINDOW_PAGE |=>
			q.memMap.physAddr[16] == $past(q.split[SPLIT_R_A16]))
		else $error("scope clear did not invert fetch");

	root_a16_a: assert property (
		memReq.valid && memReq.isData && memReq.logAddr[15:12] < q.segment_boundary_size[3:0] &&
			memReq.logAddr[15:12] < q.segment_boundary_size[7:4] &&
			memReq.logAddr[15:12] < XPC_WINDOW_PAGE |=>
			q.memMap.physAddr[16] == $past(q.split[SPLIT_R_A16]) &&
			q.memMap.zone == ZONE_ROOT)
		else $error("root data A16 inversion wrong");

	bank_after_quad_a: assert property (
		q.memValid |-> q.memMap.physAddr[19:18] == (q.memMap.quadrant ^
			{q.bank[q.memMap.quadrant][BANK_INV_A19], q.bank[q.memMap.quadrant][BANK_INV_A18]}))
		else $error("bank inversion disagrees with quadrant");

	bank0_a18_a: assert property (
		q.memValid && q.memMap.quadrant == 2'b00 && q.bank[0][BANK_INV_A18] |->
			q.memMap.physAddr[18] == 1'b1)
		else $error("bank0 A18 inversion missing");

	quad_from_split_a: assert property (
		memReq.valid && memReq.isData && memReq.logAddr[15:12] < q.segment_boundary_size[3:0] &&
			memReq.logAddr[15:12] < q.segment_boundary_size[7:4] &&
			memReq.logAddr[15:12] < XPC_WINDOW_PAGE && q.split[SPLIT_R_A19] |=>
			q.memMap.quadrant[1] == 1'b1)
		else $error("quadrant taken before split inversion");

	split_reserved_a: assert property (
		q.split[7:5] == 3'b000)
		else $error("reserved split bits set");

	force_cs_a: assert property (
		q.memValid && q.split[SPLIT_FORCE_CS2] |-> q.memMap.csSecondary)
		else $error("secondary chip select not forced");

	xpc_window_a: assert property (
		memReq.valid && memReq.logAddr[15:12] >= XPC_WINDOW_PAGE |=>
			q.memMap.zone == ZONE_XPC && q.memMap.physAddr[11:0] == $past(memReq.logAddr[11:0]))
		else $error("window access not mapped through page register");

endmodule

// ==== tb/ids_mem_model.sv ====
`timescale 1ns/1ps
// ********
// far-side memory: latches each selected access
// ********
module ids_mem_model (
	input logic clk,
	input logic rst_n,
	input logic memValid,
	input ids_pkg::ids_map_t memMap,
	output logic [19:0] seenAddr,
	output logic [1:0] seenQuad,
	output logic seenCs2
);
	import ids_pkg::*;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seenAddr <= 20'hFFFFF;
			seenQuad <= 2'h3;
			seenCs2 <= 1'b0;
		end else if (memValid) begin
			seenAddr <= memMap.physAddr;
			seenQuad <= memMap.quadrant;
			seenCs2 <= memMap.csSecondary;
		end
	end
endmodule

// ==== tb/ids_split_top_tb.sv ====
`timescale 1ns/1ps
module ids_split_top_tb;
	import ids_pkg::*;
	logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, memValid, seenCs2;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, seenQuad;
	logic [2:0] hsize;
	logic [19:0] seenAddr;
	logic [15:0] programCounter;
	logic [7:0] extendedCodePage;
	ids_req_t memReq;
	ids_xfer_t xfer;
	ids_map_t memMap;
	int failures, checksDone;
	assign hready = hreadyout;
	ids_split_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .memReq(memReq),
		.xfer(xfer), .memValid(memValid), .memMap(memMap),
		.programCounter(programCounter), .extendedCodePage(extendedCodePage));
	ids_mem_model mem (.clk(clk), .rst_n(rst_n), .memValid(memValid), .memMap(memMap),
		.seenAddr(seenAddr), .seenQuad(seenQuad), .seenCs2(seenCs2));
	// ********
	// helpers
	// ********
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic waitReady;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		waitReady();
		rd = hrdata;
		check(32'(hresp), 32'h0);
	endtask
	task automatic mapChk(input logic dat, input logic [15:0] la, input logic [19:0] pa,
		input logic [1:0] q, input ids_zone_t z);
		memReq <= '{1'b1, dat, la};
		@(posedge clk);
		memReq.valid <= 1'b0;
		#1;
		check(32'(memValid), 32'h1);
		check(32'(memMap.zone), 32'(z));
		@(posedge clk);
		#1;
		check(32'(memValid), 32'h0);
		check(32'(seenAddr), 32'(pa));
		check(32'(seenQuad), 32'(q));
		@(posedge clk);
	endtask
	task automatic jump(input logic lng, input logic [15:0] t, input logic [7:0] p);
		xfer <= '{1'b1, lng, t, p};
		@(posedge clk);
		xfer.valid <= 1'b0;
		@(posedge clk);
		check(32'(programCounter), 32'(t));
	endtask
	// ********
	// clock, reset, watchdog
	// ********
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
	// ********
	// tests
	// ********
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		memReq = '0;
		xfer = '0;
		failures = 0;
		checksDone = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, OFS_SPLIT_CTRL, 8'h00);
		check(rd, 32'h0);
		bus(1'b0, OFS_SPLIT_SCOPE, 8'h00);
		check(rd, 32'h1);
		bus(1'b0, 8'h7C, 8'h00);
		check(rd, 32'h0);
		bus(1'b1, OFS_SPLIT_CTRL, 8'hFF);
		bus(1'b0, OFS_SPLIT_CTRL, 8'h00);
		check(rd, 32'h1F);
		bus(1'b1, OFS_SPLIT_CTRL, 8'h09);
		bus(1'b1, OFS_SEG_SIZE, 8'hD4);
		bus(1'b1, OFS_DATA_BASE, 8'h02);
		bus(1'b1, OFS_XPC, 8'h05);
		mapChk(1'b0, 16'h1234, 20'h01234, 2'h0, ZONE_ROOT);
		mapChk(1'b1, 16'h1234, 20'h11234, 2'h0, ZONE_ROOT);
		mapChk(1'b1, 16'h3FFF, 20'h13FFF, 2'h0, ZONE_ROOT);
		mapChk(1'b1, 16'h4000, 20'h86000, 2'h2, ZONE_DATA);
		mapChk(1'b0, 16'h4000, 20'h06000, 2'h0, ZONE_DATA);
		mapChk(1'b1, 16'hD000, 20'h0D000, 2'h0, ZONE_STACK);
		mapChk(1'b1, 16'hE123, 20'h13123, 2'h0, ZONE_XPC);
		bus(1'b1, OFS_SPLIT_CTRL, 8'h02);
		bus(1'b1, OFS_BANK2, 8'h20);
		mapChk(1'b1, 16'h1234, 20'h01234, 2'h2, ZONE_ROOT);
		bus(1'b1, OFS_BANK0, 8'h11);
		mapChk(1'b0, 16'h1234, 20'h41234, 2'h0, ZONE_ROOT);
		check(32'(seenCs2), 32'h1);
		check(32'(memMap.csPrimary), 32'h0);
		bus(1'b1, OFS_SPLIT_SCOPE, 8'h00);
		mapChk(1'b0, 16'h1234, 20'h01234, 2'h2, ZONE_ROOT);
		bus(1'b1, OFS_BANK0, 8'h00);
		bus(1'b1, OFS_SPLIT_CTRL, 8'h10);
		mapChk(1'b0, 16'h1234, 20'h01234, 2'h0, ZONE_ROOT);
		check(32'(seenCs2), 32'h1);
		jump(1'b1, 16'hE010, 8'h21);
		check(32'(extendedCodePage), 32'h21);
		bus(1'b0, OFS_XPC, 8'h00);
		check(rd, 32'h21);
		mapChk(1'b0, 16'hF000, 20'h30000, 2'h0, ZONE_XPC);
		jump(1'b0, 16'h1000, 8'h7E);
		check(32'(extendedCodePage), 32'h21);
		bus(1'b0, OFS_PC, 8'h00);
		check(rd, 32'h1000);
		bus(1'b0, OFS_LAST_PHYS, 8'h00);
		check(rd, 32'h30000);
		check(32'(memMap.csPrimary), 32'h1);
		tally_and_finish();
	end
endmodule
